// file: hdl/dio_pkg.sv
// Purpose: shared constants and types for the digital I/O mode and interrupt control
// Assumes: byte-wide control registers reached over a select/strobe register port
// Notes:   register select codes and control field reset values are fixed here; busy output and pending resets are set in dio_mode_ctrl
package dio_pkg;

  // module build variant
  typedef enum logic [1:0] {
    DIO_VAR_LOGIC,
    DIO_VAR_OPEN_COLLECTOR_VARIANT,
    DIO_VAR_HIGH_VOLTAGE_OPEN_COLLECTOR_VARIANT
  } dio_variant_type;

  localparam int DIO_NUM_PORTS = 12;
  localparam int DIO_NUM_DIR   = 4;
  localparam int DIO_HV_PORTS  = 6;
  localparam int DIO_SPAN_W    = 4;

  // register select codes
  localparam logic DIO_REG_DIR_SPAN = 1'b0;
  localparam logic DIO_REG_IRQ_CTRL = 1'b1;

  // port_direction_and_sync_span fields
  localparam int DIO_DIR_LSB  = 0;
  localparam int DIO_SPAN_LSB = 4;

  // interrupt_and_handshake_control fields
  localparam int DIO_IEN_BIT      = 0;
  localparam int DIO_BUSY_POL_BIT = 1;
  localparam int DIO_CLK_EDGE_BIT = 2;
  localparam int DIO_TRIG_BIT     = 5;
  localparam int DIO_SVC_BIT      = 6;
  localparam int DIO_LINE_BIT     = 7;

  // span codes meaning every port synchronous
  localparam logic [DIO_SPAN_W-1:0] DIO_SPAN_ALL_LOGIC = 4'hb;
  localparam logic [DIO_SPAN_W-1:0] DIO_SPAN_ALL_HV    = 4'h6;

  // reset values
  localparam logic [DIO_NUM_DIR-1:0] DIO_DIR_RST  = 4'h0;
  localparam logic [DIO_SPAN_W-1:0]  DIO_SPAN_RST = 4'h0;
  localparam logic                   DIO_IEN_RST  = 1'b0;
  localparam logic                   DIO_POL_RST  = 1'b0;
  localparam logic                   DIO_EDGE_RST = 1'b0;

endpackage

// file: hdl/dio_pin_if.sv
// Purpose: carries synchronised external pin levels and clock edges between modules
// Assumes: all signals on ref_clk
// Notes:   edge pulses last one enabled cycle
`timescale 1ns/1ps
`default_nettype none
interface dio_pin_if;
  logic       clk_rise;
  logic       clk_fall;
  logic       trig_lvl;
  logic [3:0] tri_n_lvl;

  modport sync (output clk_rise, output clk_fall, output trig_lvl, output tri_n_lvl);
  modport core (input clk_rise, input clk_fall, input trig_lvl, input tri_n_lvl);
endinterface
`default_nettype wire

// file: hdl/dio_pin_sync.sv
// Purpose: two-stage synchronisers for external pins and edge detection for the clock pin
// Assumes: pins asynchronous to ref_clk; external clock slow against ref_clk
// Notes:   edges are taken from the second stage against a third history stage
`timescale 1ns/1ps
`default_nettype none
module dio_pin_sync (
  // clock and reset
  input  wire logic  ref_clk,
  input  wire logic  srst,
  input  wire logic  ce,
  // raw pins
  input  wire logic  ext_clk_pin,
  input  wire logic  ext_trig_pin,
  input  wire logic [3:0] tri_n_pin,
  // synchronised side
  dio_pin_if.sync    pins
);
  import dio_pkg::*;

  localparam int W = 2 + DIO_NUM_DIR;

  logic [W-1:0] s1_r;
  logic [W-1:0] s1_nxt;
  logic [W-1:0] s2_r;
  logic [W-1:0] s2_nxt;
  logic         clk_hist_r;
  logic         clk_hist_nxt;

  always_comb begin
    s1_nxt       = {tri_n_pin, ext_trig_pin, ext_clk_pin};
    s2_nxt       = s1_r;
    clk_hist_nxt = s2_r[0];
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s1_r       <= '0;
      s2_r       <= '0;
      clk_hist_r <= 1'b0;
    end else if (ce) begin
      s1_r       <= s1_nxt;
      s2_r       <= s2_nxt;
      clk_hist_r <= clk_hist_nxt;
    end
  end

  // gated by ce so a frozen block sees no edge
  assign pins.clk_rise  = ce & s2_r[0] & ~clk_hist_r;
  assign pins.clk_fall  = ce & ~s2_r[0] & clk_hist_r;
  assign pins.trig_lvl  = s2_r[1];
  assign pins.tri_n_lvl = s2_r[W-1:2];
endmodule
`default_nettype wire

// file: hdl/dio_mode_ctrl.sv
// Purpose: port direction, synchronous span, busy polarity, clock edge and interrupt control
// Assumes: variant input is static; busy_req and svc_event come from ref_clk logic
// Notes:   registers reached by select, write strobe and read strobe, one byte each
// Operation
// - bits 0-3 set ports I-L direction
// - direction readback inverted, tri-state low reads 1
// - bits 4-7 code sets synchronous port prefix
// - open-collector: direction bits dead, span kept
// - high-voltage: direction dead, span over A-F
// - bit0 enables interrupts; bit6 low when pending
// - bit1 selects busy output polarity
// - bit2 selects external clock active edge
// - bit5 reads external trigger level
`timescale 1ns/1ps
`default_nettype none
module dio_mode_ctrl (
  // clock, reset, enable
  input  wire logic                              ref_clk,
  input  wire logic                              srst,
  input  wire logic                              ce,
  // build variant
  input  wire dio_pkg::dio_variant_type          variant,
  // register port
  input  wire logic                              reg_sel,
  input  wire logic                              reg_wr,
  input  wire logic                              reg_rd,
  input  wire logic [7:0]                        reg_wdata,
  output logic      [7:0]                        reg_rdata,
  output logic                                   reg_rvalid,
  // external equipment pins
  input  wire logic                              ext_clk_pin,
  input  wire logic                              ext_trig_pin,
  input  wire logic [dio_pkg::DIO_NUM_DIR-1:0]   tri_n_pin,
  output logic                                   ext_busy_pin,
  // port logic side
  input  wire logic                              busy_req,
  input  wire logic                              svc_event,
  output logic                                   ext_clk_strobe,
  output logic                                   trig_active,
  output logic      [dio_pkg::DIO_NUM_DIR-1:0]   port_dir_out,
  output logic      [dio_pkg::DIO_NUM_PORTS-1:0] sync_mask,
  output logic                                   irq_line
);
  import dio_pkg::*;

  dio_pin_if pins ();

  dio_pin_sync u_sync (
    .ref_clk      (ref_clk),
    .srst         (srst),
    .ce           (ce),
    .ext_clk_pin  (ext_clk_pin),
    .ext_trig_pin (ext_trig_pin),
    .tri_n_pin    (tri_n_pin),
    .pins         (pins)
  );

  // control state
  logic [DIO_NUM_DIR-1:0]   dir_r;
  logic [DIO_NUM_DIR-1:0]   dir_nxt;
  logic [DIO_SPAN_W-1:0]    span_r;
  logic [DIO_SPAN_W-1:0]    span_nxt;
  logic                     ien_r;
  logic                     ien_nxt;
  logic                     pol_r;
  logic                     pol_nxt;
  logic                     edge_r;
  logic                     edge_nxt;
  logic                     pending_r;
  logic                     pending_nxt;

  // output state
  logic [7:0]               rdata_r;
  logic [7:0]               rdata_nxt;
  logic                     rvalid_r;
  logic                     rvalid_nxt;
  logic                     busy_r;
  logic                     busy_nxt;
  logic                     strobe_r;
  logic                     strobe_nxt;
  logic                     trig_r;
  logic                     trig_nxt;
  logic [DIO_NUM_DIR-1:0]   dir_out_r;
  logic [DIO_NUM_DIR-1:0]   dir_out_nxt;
  logic [DIO_NUM_PORTS-1:0] mask_r;
  logic [DIO_NUM_PORTS-1:0] mask_nxt;
  logic                     line_r;
  logic                     line_nxt;

  logic                     is_logic;
  logic                     is_hv;
  logic                     wr_dir;
  logic                     wr_ctl;
  logic [7:0]               rd_dir_span;
  logic [7:0]               rd_irq_ctrl;

  assign is_logic = (variant == DIO_VAR_LOGIC);
  assign is_hv    = (variant == DIO_VAR_HIGH_VOLTAGE_OPEN_COLLECTOR_VARIANT);
  assign wr_dir   = reg_wr & (reg_sel == DIO_REG_DIR_SPAN);
  assign wr_ctl   = reg_wr & (reg_sel == DIO_REG_IRQ_CTRL);

  // register writes
  always_comb begin
    dir_nxt  = dir_r;
    span_nxt = span_r;
    ien_nxt  = ien_r;
    pol_nxt  = pol_r;
    edge_nxt = edge_r;
    if (wr_dir) begin
      if (is_logic) begin
        dir_nxt = reg_wdata[DIO_DIR_LSB +: DIO_NUM_DIR];
      end else begin
        dir_nxt = DIO_DIR_RST;
      end
      span_nxt = reg_wdata[DIO_SPAN_LSB +: DIO_SPAN_W];
    end
    // reserved bits 3 and 4 are not stored
    if (wr_ctl) begin
      ien_nxt  = reg_wdata[DIO_IEN_BIT];
      pol_nxt  = reg_wdata[DIO_BUSY_POL_BIT];
      edge_nxt = reg_wdata[DIO_CLK_EDGE_BIT];
    end
  end

  // interrupt pending: set by event, cleared by a read of the control byte
  always_comb begin
    pending_nxt = pending_r;
    if (reg_rd && (reg_sel == DIO_REG_IRQ_CTRL)) begin
      pending_nxt = 1'b0;
    end
    if (svc_event) begin
      pending_nxt = 1'b1;
    end
  end

  // readback images
  always_comb begin
    rd_dir_span = 8'h00;
    if (is_logic) begin
      rd_dir_span[DIO_DIR_LSB +: DIO_NUM_DIR] = ~dir_r | ~pins.tri_n_lvl;
    end
    rd_dir_span[DIO_SPAN_LSB +: DIO_SPAN_W] = span_r;
    rd_irq_ctrl                   = 8'h00;
    rd_irq_ctrl[DIO_IEN_BIT]      = ien_r;
    rd_irq_ctrl[DIO_BUSY_POL_BIT] = pol_r;
    rd_irq_ctrl[DIO_CLK_EDGE_BIT] = edge_r;
    rd_irq_ctrl[DIO_TRIG_BIT]     = pins.trig_lvl;
    rd_irq_ctrl[DIO_SVC_BIT]      = ~pending_r;
    rd_irq_ctrl[DIO_LINE_BIT]     = ~line_r;
  end

  // read answer
  always_comb begin
    rdata_nxt  = rdata_r;
    rvalid_nxt = reg_rd;
    if (reg_rd) begin
      rdata_nxt = (reg_sel == DIO_REG_IRQ_CTRL) ? rd_irq_ctrl : rd_dir_span;
    end
  end

  // synchronous span per port
  genvar p;
  generate
    for (p = 0; p < DIO_NUM_PORTS; p++) begin : g_span
      localparam logic [DIO_SPAN_W-1:0] PIDX = DIO_SPAN_W'(p);
      if (p < DIO_HV_PORTS) begin : g_low
        assign mask_nxt[p] = is_hv ? ((span_r > PIDX) || (span_r >= DIO_SPAN_ALL_HV))
                                   : ((span_r > PIDX) || (span_r >= DIO_SPAN_ALL_LOGIC));
      end else begin : g_high
        assign mask_nxt[p] = ~is_hv & ((span_r > PIDX) || (span_r >= DIO_SPAN_ALL_LOGIC));
      end
    end
  endgenerate

  // pin side and port logic outputs
  always_comb begin
    busy_nxt    = pol_r ? busy_req : ~busy_req;
    strobe_nxt  = edge_r ? pins.clk_fall : pins.clk_rise;
    trig_nxt    = pins.trig_lvl;
    dir_out_nxt = is_logic ? dir_r : DIO_DIR_RST;
    line_nxt    = ien_r & pending_r;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      dir_r     <= DIO_DIR_RST;
      span_r    <= DIO_SPAN_RST;
      ien_r     <= DIO_IEN_RST;
      pol_r     <= DIO_POL_RST;
      edge_r    <= DIO_EDGE_RST;
      pending_r <= 1'b0;
      rdata_r   <= 8'h00;
      rvalid_r  <= 1'b0;
      busy_r    <= 1'b1;
      strobe_r  <= 1'b0;
      trig_r    <= 1'b0;
      dir_out_r <= DIO_DIR_RST;
      mask_r    <= '0;
      line_r    <= 1'b0;
    end else if (ce) begin
      dir_r     <= dir_nxt;
      span_r    <= span_nxt;
      ien_r     <= ien_nxt;
      pol_r     <= pol_nxt;
      edge_r    <= edge_nxt;
      pending_r <= pending_nxt;
      rdata_r   <= rdata_nxt;
      rvalid_r  <= rvalid_nxt;
      busy_r    <= busy_nxt;
      strobe_r  <= strobe_nxt;
      trig_r    <= trig_nxt;
      dir_out_r <= dir_out_nxt;
      mask_r    <= mask_nxt;
      line_r    <= line_nxt;
    end
  end

  assign reg_rdata      = rdata_r;
  assign reg_rvalid     = rvalid_r;
  assign ext_busy_pin   = busy_r;
  assign ext_clk_strobe = strobe_r;
  assign trig_active    = trig_r;
  assign port_dir_out   = dir_out_r;
  assign sync_mask      = mask_r;
  assign irq_line       = line_r;

endmodule
`default_nettype wire

// file: sim/dio_ctrl_monitor.sv
// Purpose: port-level checks of the mode and interrupt control block
// Assumes: variant changes only while srst is high
// Notes:   shadow copies of the two control bytes track host writes
`timescale 1ns/1ps
`default_nettype none
module dio_ctrl_monitor
  import dio_pkg::*;
(
  // clock and control
  input wire logic            ref_clk,
  input wire logic            srst,
  input wire logic            ce,
  input wire dio_variant_type variant,
  // register port
  input wire logic            reg_sel,
  input wire logic            reg_wr,
  input wire logic            reg_rd,
  input wire logic [7:0]      reg_wdata,
  input wire logic [7:0]      reg_rdata,
  input wire logic            reg_rvalid,
  // pins and port side
  input wire logic            ext_trig_pin,
  input wire logic            ext_busy_pin,
  input wire logic            busy_req,
  input wire logic            svc_event,
  input wire logic            ext_clk_strobe,
  input wire logic            trig_active,
  input wire logic [3:0]      port_dir_out,
  input wire logic [11:0]     sync_mask,
  input wire logic            irq_line
);
  logic [7:0] sh0_r, sh0_nxt, sh1_r, sh1_nxt;
  function automatic logic [11:0] span_mask(logic [3:0] k, dio_variant_type v);
    if (v == DIO_VAR_HIGH_VOLTAGE_OPEN_COLLECTOR_VARIANT)
      return (k >= 4'h6) ? 12'h03f : 12'((1 << k) - 1);
    return (k >= 4'hb) ? 12'hfff : 12'((1 << k) - 1);
  endfunction
  always_comb begin
    sh0_nxt = (ce && reg_wr && !reg_sel) ? reg_wdata : sh0_r;
    sh1_nxt = (ce && reg_wr && reg_sel) ? reg_wdata : sh1_r;
    if (srst) begin
      sh0_nxt = 8'h00;
      sh1_nxt = 8'h00;
    end
  end
  always_ff @(posedge ref_clk) begin
    sh0_r <= sh0_nxt;
    sh1_r <= sh1_nxt;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  a_read_answer: assert property (ce && reg_rd |=> reg_rvalid)
    else $error("read not answered");
  a_rvalid_cause: assert property (reg_rvalid |-> $past(reg_rd))
    else $error("read valid without read");
  a_rdata_hold: assert property ($changed(reg_rdata) |-> reg_rvalid)
    else $error("read data moved");
  a_dir_follow: assert property ($past(ce) |-> port_dir_out ==
    ((variant == DIO_VAR_LOGIC) ? $past(sh0_r[3:0]) : 4'h0)) else $error("direction wrong");
  a_span_mask: assert property ($past(ce) |->
    sync_mask == span_mask($past(sh0_r[7:4]), variant)) else $error("sync mask wrong");
  a_busy_pol: assert property ($past(ce) |->
    ext_busy_pin == ($past(sh1_r[1]) ~^ $past(busy_req))) else $error("busy level wrong");
  a_irq_mask: assert property (irq_line |-> $past(sh1_r[0]))
    else $error("irq while disabled");
  a_irq_raise: assert property (ce && svc_event && sh1_r[0] ##1 sh1_r[0] |=> irq_line)
    else $error("irq not raised");
  a_trig_delay: assert property (trig_active == $past(ext_trig_pin, 3))
    else $error("trigger level wrong");
  a_strobe_pulse: assert property (ext_clk_strobe |=> !ext_clk_strobe)
    else $error("strobe too long");
  c_irq: cover property (irq_line);
  c_strobe: cover property (ext_clk_strobe);
  c_all_sync: cover property (sync_mask == 12'hfff);
endmodule
`default_nettype wire

// file: sim/dio_ext_model.sv
// Purpose: external equipment driving clock, trigger and tri-state pins
// Assumes: bench sets the levels it wants seen
// Notes:   link clock of 80 ns stands low outside frames
`timescale 1ns/1ps
`default_nettype none
module dio_ext_model (
  // bench control
  input wire logic       frame_on,
  input wire logic       trig_set,
  input wire logic [3:0] hold_set,
  // pins
  output logic           ext_clk_pin,
  output logic           ext_trig_pin,
  output logic [3:0]     tri_n_pin,
  input wire logic       ext_busy_pin
);
  // both edge senses appear within a frame; phase unrelated to ref_clk
  initial begin
    ext_clk_pin = 1'b0;
    #3;
    forever #40 ext_clk_pin = frame_on ? !ext_clk_pin : 1'b0;
  end
  assign ext_trig_pin = trig_set;
  assign tri_n_pin = ~hold_set;
endmodule
`default_nettype wire

// file: sim/dio_mode_ctrl_tb.sv
// Purpose: self-checking bench for the mode and interrupt control block
// Assumes: ce held high except for one frozen write; register port driven by select and strobes
// Notes:   each variant is entered through a reset
`timescale 1ns/1ps
`default_nettype none
module dio_mode_ctrl_tb;
  import dio_pkg::*;
  logic ref_clk = 1'b0, srst = 1'b1, ce = 1'b1, reg_sel = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic busy_req = 1'b0, svc_event = 1'b0, frame_on = 1'b0, trig_set = 1'b0, edge_sel = 1'b0;
  logic reg_rvalid, ext_busy_pin, ext_clk_strobe, trig_active, irq_line, ext_clk_pin;
  logic ext_trig_pin;
  logic [7:0] reg_wdata = 8'h00, reg_rdata;
  logic [3:0] hold_set = 4'h0, port_dir_out, tri_n_pin;
  logic [11:0] sync_mask;
  logic [1:0] pin_h = 2'h0;
  dio_variant_type variant = DIO_VAR_LOGIC;
  int error_cnt = 0, compares = 0, strobes = 0;
  always #5 ref_clk = ~ref_clk;
  dio_mode_ctrl dio_mode_ctrl_inst (.ref_clk, .srst, .ce, .variant, .reg_sel, .reg_wr, .reg_rd,
    .reg_wdata, .reg_rdata, .reg_rvalid, .ext_clk_pin, .ext_trig_pin, .tri_n_pin, .ext_busy_pin,
    .busy_req, .svc_event, .ext_clk_strobe, .trig_active, .port_dir_out, .sync_mask, .irq_line);
  dio_ext_model dio_ext_model_inst (.frame_on, .trig_set, .hold_set, .ext_clk_pin,
    .ext_trig_pin, .tri_n_pin, .ext_busy_pin);
  task automatic chk(string nm, logic [11:0] exp, logic [11:0] got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(logic sel, logic [7:0] d);
    @(posedge ref_clk);
    reg_sel <= sel;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic sel, logic [7:0] exp);
    @(posedge ref_clk);
    reg_sel <= sel;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk("rvalid", 12'h001, 12'(reg_rvalid));
    chk("rdata", 12'(exp), 12'(reg_rdata));
  endtask
  task automatic rst(dio_variant_type v);
    @(posedge ref_clk);
    srst <= 1'b1;
    variant <= v;
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
  endtask
  task automatic svc_pulse;
    @(posedge ref_clk);
    svc_event <= 1'b1;
    @(posedge ref_clk);
    svc_event <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask
  task automatic complete_run;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // strobe must land while the pin, as sampled two cycles earlier, shows the selected edge's new level
  always @(posedge ref_clk) begin
    pin_h <= {pin_h[0], ext_clk_pin};
    if (ext_clk_strobe === 1'b1) begin
      strobes++;
      chk("clk_edge", 12'(!edge_sel), 12'(pin_h[1]));
    end
  end
  initial begin
    #100000;
    error_cnt++;
    complete_run;
  end
  initial begin
    rst(DIO_VAR_LOGIC);
    #1 chk("busy_rst", 12'h001, 12'(ext_busy_pin));
    rd(1'b0, 8'h0f);
    rd(1'b1, 8'hc0);
    for (int v = 0; v < 3; v++) begin
      rst(dio_variant_type'(v));
      for (int k = 0; k < 16; k++) begin
        wr(1'b0, {4'(k), 4'h7});
        rd(1'b0, {4'(k), (v == 0) ? 4'h8 : 4'h0});
      end
      chk("dir_out", (v == 0) ? 12'h007 : 12'h000, 12'(port_dir_out));
      chk("sync_mask", (v == 2) ? 12'h03f : 12'hfff, sync_mask);
    end
    rst(DIO_VAR_LOGIC);
    wr(1'b0, 8'h37);
    hold_set <= 4'h1;
    repeat (4) @(posedge ref_clk);
    rd(1'b0, 8'h39);
    wr(1'b1, 8'h01);
    svc_pulse;
    chk("irq", 12'h001, 12'(irq_line));
    rd(1'b1, 8'h01);
    rd(1'b1, 8'hc1);
    chk("irq", 12'h000, 12'(irq_line));
    wr(1'b1, 8'h00);
    svc_pulse;
    rd(1'b1, 8'h80);
    chk("irq", 12'h000, 12'(irq_line));
    wr(1'b1, 8'h02);
    busy_req <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1 chk("busy", 12'h001, 12'(ext_busy_pin));
    wr(1'b1, 8'h00);
    repeat (2) @(posedge ref_clk);
    #1 chk("busy", 12'h000, 12'(ext_busy_pin));
    busy_req <= 1'b0;
    trig_set <= 1'b1;
    repeat (5) @(posedge ref_clk);
    rd(1'b1, 8'he0);
    chk("trig", 12'h001, 12'(trig_active));
    trig_set <= 1'b0;
    for (int e = 0; e < 2; e++) begin
      wr(1'b1, 8'(e << 2));
      edge_sel <= 1'(e);
      strobes = 0;
      frame_on <= 1'b1;
      repeat (24) @(posedge ref_clk);
      frame_on <= 1'b0;
      repeat (10) @(posedge ref_clk);
      chk("strobes", 12'h003, 12'(strobes));
    end
    // a write made while the block is frozen must not land
    ce <= 1'b0;
    wr(1'b0, 8'h00);
    ce <= 1'b1;
    rd(1'b0, 8'h39);
    complete_run;
  end
endmodule
bind dio_mode_ctrl dio_ctrl_monitor dio_ctrl_monitor_inst (.ref_clk, .srst, .ce, .variant,
  .reg_sel, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_rvalid, .ext_trig_pin, .ext_busy_pin,
  .busy_req, .svc_event, .ext_clk_strobe, .trig_active, .port_dir_out, .sync_mask, .irq_line);
`default_nettype wire
